/* File: hw/ssci_pkg.sv */
// ssci_pkg: register map, field positions, reset values, fifo sizes and identity codes for the serial channel block
// assumes: a plain register port with 32-bit data, one system clock
package ssci_pkg;
	localparam int          SSCI_CHANNELS     = 4;
	localparam int          SSCI_ADDR_W       = 12;
	// per-channel register groups, channel n at base + 4*n; SSCI_FW_KIND and SSCI_CAPS are single registers
	localparam logic [11:0] SSCI_LINE_CFG_BASE = 12'h080;
	localparam logic [11:0] SSCI_PIN_STAT_BASE = 12'h090;
	localparam logic [11:0] SSCI_OSC_PROG_BASE = 12'h0A0;
	localparam logic [11:0] SSCI_TX_GAP_BASE   = 12'h0B0;
	localparam logic [11:0] SSCI_RX_BITS_BASE  = 12'h0C0;
	localparam logic [11:0] SSCI_FIFO_LVL_BASE = 12'h0D0;
	localparam logic [11:0] SSCI_FIFO_CAP_BASE = 12'h0E0;
	localparam logic [11:0] SSCI_CTRL_BASE     = 12'h100;
	localparam logic [11:0] SSCI_TX_DATA_BASE  = 12'h110;
	localparam logic [11:0] SSCI_RX_DATA_BASE  = 12'h120;
	localparam logic [11:0] SSCI_FW_KIND       = 12'h0F8;
	localparam logic [11:0] SSCI_CAPS          = 12'h0FC;
	// line configuration fields
	localparam int SSCI_LB_BIT      = 23;
	localparam int SSCI_SEND_CLOCK_IDLE_CONTROL_BIT = 20;
	localparam int SSCI_TXD_IDL_BIT = 19;
	localparam int SSCI_RXD_POL_BIT = 16;
	localparam int SSCI_RXE_LSB     = 14;
	localparam int SSCI_RXC_EDG_BIT = 13;
	localparam int SSCI_SP_LSB      = 11;
	localparam int SSCI_AUX_LSB     = 9;
	localparam int SSCI_TXD_LSB     = 6;
	localparam int SSCI_TXE_LSB     = 4;
	localparam int SSCI_TXC_GATE_BIT = 3;
	localparam int SSCI_TXC_LSB     = 0;
	// control register fields
	localparam int SSCI_CTL_TXEN_BIT = 0;
	localparam int SSCI_CTL_LSBF_BIT = 1;
	localparam int SSCI_CTL_RCLR_BIT = 2;
	localparam int SSCI_CTL_DIV_LSB  = 8;
	localparam int SSCI_CTL_DIV_W    = 8;
	// reset values
	localparam logic [31:0] SSCI_LINE_CFG_RST = 32'h0000_0000;
	localparam logic [31:0] SSCI_TX_GAP_RST   = 32'h0000_0008;
	localparam logic [15:0] SSCI_RX_SIZE_RST  = 16'h0000;
	localparam logic [31:0] SSCI_CTRL_RST     = 32'h0000_0400;
	// fifos, sizes reported as fixed build values
	localparam int          SSCI_FIFO_DEPTH   = 16;
	localparam int          SSCI_FIFO_AW      = 4;
	localparam logic [15:0] SSCI_FIFO_SIZE    = 16'h0010;
	// identity: value is arbitrary
	localparam logic [7:0]  SSCI_FW_KIND_CODE = 8'h5C;
	localparam logic [31:0] SSCI_CAPS_CODE    = 32'h0080_1020;
	localparam logic [31:0] SSCI_UNMAPPED     = 32'h0000_0000;
endpackage : ssci_pkg

/* File: hw/ssci_top.sv */
// ssci_top: four independent synchronous serial channels with pin configuration,
// word framing, bit counting, pin monitoring and small data fifos.
// assumes: pins sampled synchronous to sys_clk, external clock slow against sys_clk.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module ssci_top
	import ssci_pkg::*;
(
	input  wire logic                     sys_clk,
	input  wire logic                     reset_n,
	input  wire logic [SSCI_ADDR_W-1:0]   reg_addr,
	input  wire logic [31:0]              reg_wdata,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	output logic      [31:0]              reg_rdata,
	input  wire logic [SSCI_CHANNELS-1:0] ext_clock_in,
	input  wire logic [SSCI_CHANNELS-1:0] receive_clock_line,
	input  wire logic [SSCI_CHANNELS-1:0] receive_data_line,
	input  wire logic [SSCI_CHANNELS-1:0] receive_envelope_line,
	input  wire logic [SSCI_CHANNELS-1:0] auxiliary_clock_in,
	input  wire logic [SSCI_CHANNELS-1:0] spare_line_in,
	output logic      [SSCI_CHANNELS-1:0] send_clock_line,
	output logic      [SSCI_CHANNELS-1:0] send_data_line,
	output logic      [SSCI_CHANNELS-1:0] send_envelope_line,
	output logic      [SSCI_CHANNELS-1:0] auxiliary_clock_out,
	output logic      [SSCI_CHANNELS-1:0] auxiliary_clock_oe,
	output logic      [SSCI_CHANNELS-1:0] spare_line_out,
	output logic      [SSCI_CHANNELS-1:0] spare_line_oe
);
	typedef enum logic [2:0] {
		SSCI_IDLE = 3'b001,
		SSCI_SEND = 3'b010,
		SSCI_GAP  = 3'b100
	} ssci_tx_state_t;

	function automatic logic ssci_hit(input logic [11:0] a, input logic [11:0] base, input int ch);
		ssci_hit = (a == base + 12'(4 * ch));
	endfunction : ssci_hit

	function automatic logic [2:0] ssci_bitpos(input logic lsb_first, input logic [2:0] idx);
		ssci_bitpos = lsb_first ? idx : 3'(7 - idx);
	endfunction : ssci_bitpos

	logic [31:0] rdata_d;
	genvar c;
	for (c = 0; c < SSCI_CHANNELS; c++) begin : g_ch
		logic [31:0]    cfg_q;
		logic [31:0]    gap_q;
		logic [15:0]    rx_size_q;
		logic [31:0]    ctrl_q;
		logic [7:0]     tx_mem [SSCI_FIFO_DEPTH];
		logic [7:0]     rx_mem [SSCI_FIFO_DEPTH];
		logic [SSCI_FIFO_AW:0] tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
		logic [SSCI_FIFO_AW:0] tx_cnt, rx_cnt;
		logic [7:0]     div_q;
		logic           prog_q, prog_half_q;
		logic           aux_q, ext_q;
		ssci_tx_state_t st_q;
		logic [15:0]    bits_left_q;
		logic [15:0]    gap_left_q;
		logic [2:0]     bit_idx_q;
		logic [7:0]     sh_q;
		logic           byte_ok_q;
		logic           txd_q, env_q;
		logic           tx_pop, src_clk, src_prev_q, tick_change, tick_other;
		logic           txc_live;
		logic           rxc_in, rxd_in, rxe_in, rxc_prev_q;
		logic           rx_env, rx_env_prev_q, rx_sample;
		logic [15:0]    rx_cnt_q;
		logic [15:0]    rx_word_bits_q;
		logic [2:0]     rx_idx_q;
		logic [7:0]     rx_sh_q;
		logic           rx_push, rx_close_bits;
		logic [7:0]     rx_byte;
		logic           dbit;

		assign tx_cnt = tx_wp_q - tx_rp_q;
		assign rx_cnt = rx_wp_q - rx_rp_q;

		// register writes; each channel decodes its own copy
		always_ff @(posedge sys_clk or negedge reset_n)
		begin
			if (!reset_n)
			begin
				cfg_q     <= SSCI_LINE_CFG_RST;
				gap_q     <= SSCI_TX_GAP_RST;
				rx_size_q <= SSCI_RX_SIZE_RST;
				ctrl_q    <= SSCI_CTRL_RST;
			end
			else
			begin
				ctrl_q[SSCI_CTL_RCLR_BIT] <= 1'b0;
				if (reg_wr && ssci_hit(reg_addr, SSCI_LINE_CFG_BASE, c))
					cfg_q <= reg_wdata;
				if (reg_wr && ssci_hit(reg_addr, SSCI_TX_GAP_BASE, c))
					gap_q <= reg_wdata;
				if (reg_wr && ssci_hit(reg_addr, SSCI_RX_BITS_BASE, c))
					rx_size_q <= reg_wdata[31:16];
				if (reg_wr && ssci_hit(reg_addr, SSCI_CTRL_BASE, c))
					ctrl_q <= reg_wdata;
			end
		end

		// transmit fifo
		always_ff @(posedge sys_clk or negedge reset_n)
		begin
			if (!reset_n)
			begin
				tx_wp_q <= '0;
				tx_rp_q <= '0;
			end
			else
			begin
				// writes to a full fifo are dropped
				if (reg_wr && ssci_hit(reg_addr, SSCI_TX_DATA_BASE, c) && tx_cnt != SSCI_FIFO_DEPTH)
				begin
					tx_mem[tx_wp_q[SSCI_FIFO_AW-1:0]] <= reg_wdata[7:0];
					tx_wp_q <= tx_wp_q + 1'b1;
				end
				if (tx_pop)
					tx_rp_q <= tx_rp_q + 1'b1;
			end
		end

		// programmable clock: divider toggles an internal level, halved again
		always_ff @(posedge sys_clk or negedge reset_n)
		begin
			if (!reset_n)
			begin
				div_q       <= '0;
				prog_q      <= 1'b0;
				prog_half_q <= 1'b0;
				aux_q       <= 1'b0;
				ext_q       <= 1'b0;
			end
			else
			begin
				ext_q <= ext_clock_in[c];
				aux_q <= prog_half_q;
				if (div_q >= ctrl_q[SSCI_CTL_DIV_LSB +: SSCI_CTL_DIV_W])
				begin
					div_q  <= '0;
					prog_q <= ~prog_q;
					if (prog_q)
						prog_half_q <= ~prog_half_q;
				end
				else
					div_q <= div_q + 8'h01;
			end
		end

		assign src_clk = cfg_q[SSCI_TXC_LSB+1] ? ext_q : prog_half_q;
		always_ff @(posedge sys_clk or negedge reset_n)
		begin
			if (!reset_n)
				src_prev_q <= 1'b0;
			else
				src_prev_q <= src_clk;
		end
		// change edge per low select bit; the opposite edge is where the far side samples
		assign tick_change = cfg_q[SSCI_TXC_LSB] ? (src_prev_q & ~src_clk) : (~src_prev_q & src_clk);
		assign tick_other  = cfg_q[SSCI_TXC_LSB] ? (~src_prev_q & src_clk) : (src_prev_q & ~src_clk);

		// word framer: words of send_word_length bits, interword_idle_count plus one idle clocks between
		assign tx_pop = tick_change && (tx_cnt != '0) && ctrl_q[SSCI_CTL_TXEN_BIT]
			&& ((st_q == SSCI_IDLE && gap_q[15:0] != '0)
			|| (st_q == SSCI_SEND && bit_idx_q == 3'h0 && !byte_ok_q && bits_left_q != '0)
			|| (st_q == SSCI_SEND && bit_idx_q == 3'h7 && bits_left_q > 16'h0001));
		always_ff @(posedge sys_clk or negedge reset_n)
		begin
			if (!reset_n)
			begin
				st_q        <= SSCI_IDLE;
				bits_left_q <= '0;
				gap_left_q  <= '0;
				bit_idx_q   <= '0;
				sh_q        <= '0;
				byte_ok_q   <= 1'b0;
				txd_q       <= 1'b0;
				env_q       <= 1'b0;
			end
			else if (tick_change)
			begin
				case (st_q)
					SSCI_IDLE:
					begin
						env_q <= 1'b0;
						if (tx_pop)
						begin
							// starts as soon as one byte is present
							sh_q        <= tx_mem[tx_rp_q[SSCI_FIFO_AW-1:0]];
							st_q        <= SSCI_SEND;
							env_q       <= 1'b1;
							txd_q       <= tx_mem[tx_rp_q[SSCI_FIFO_AW-1:0]][ssci_bitpos(ctrl_q[SSCI_CTL_LSBF_BIT], 3'h0)];
							bit_idx_q   <= 3'h1;
							bits_left_q <= gap_q[15:0] - 16'h0001;
						end
					end
					SSCI_SEND:
					begin
						if (bits_left_q == '0)
						begin
							env_q      <= 1'b0;
							gap_left_q <= gap_q[31:16];
							st_q       <= (gap_q[31:16] == '0) ? SSCI_IDLE : SSCI_GAP;
						end
						else if (bit_idx_q == 3'h0 && !byte_ok_q)
						begin
							// fifo ran dry mid-word: idle here until the next byte arrives
							env_q <= 1'b0;
						end
						else
						begin
							env_q       <= 1'b1;
							txd_q       <= sh_q[ssci_bitpos(ctrl_q[SSCI_CTL_LSBF_BIT], bit_idx_q)];
							bit_idx_q   <= bit_idx_q + 3'h1;
							bits_left_q <= bits_left_q - 16'h0001;
						end
						if (tx_pop)
						begin
							sh_q      <= tx_mem[tx_rp_q[SSCI_FIFO_AW-1:0]];
							byte_ok_q <= 1'b1;
						end
						else if (bit_idx_q == 3'h7)
							byte_ok_q <= 1'b0;
					end
					SSCI_GAP:
					begin
						env_q <= 1'b0;
						if (gap_left_q <= 16'h0001)
							st_q <= SSCI_IDLE;
						gap_left_q <= gap_left_q - 16'h0001;
					end
					default:
						st_q <= SSCI_IDLE;
				endcase
			end
		end

		// pins
		always_comb
		begin
			txc_live = cfg_q[SSCI_TXC_LSB] ? ~src_clk : src_clk;
			if (cfg_q[SSCI_TXC_LSB+2])
				send_clock_line[c] = cfg_q[SSCI_TXC_LSB];
			else if (!env_q && cfg_q[SSCI_TXC_GATE_BIT])
				send_clock_line[c] = cfg_q[SSCI_SEND_CLOCK_IDLE_CONTROL_BIT];
			else
				send_clock_line[c] = txc_live;
			if (cfg_q[SSCI_TXD_LSB+2])
				send_data_line[c] = cfg_q[SSCI_TXD_LSB];
			else if (!env_q)
				send_data_line[c] = cfg_q[SSCI_TXD_IDL_BIT];
			else
				send_data_line[c] = txd_q ^ cfg_q[SSCI_TXD_LSB];
			if (cfg_q[SSCI_TXE_LSB+1])
				send_envelope_line[c] = cfg_q[SSCI_TXE_LSB];
			else
				send_envelope_line[c] = env_q ^ cfg_q[SSCI_TXE_LSB];
			auxiliary_clock_oe[c]  = cfg_q[SSCI_AUX_LSB +: 2] != 2'b00;
			auxiliary_clock_out[c] = (cfg_q[SSCI_AUX_LSB +: 2] == 2'b01) ? aux_q
				: cfg_q[SSCI_AUX_LSB];
			spare_line_oe[c]  = cfg_q[SSCI_SP_LSB+1];
			spare_line_out[c] = cfg_q[SSCI_SP_LSB] & cfg_q[SSCI_SP_LSB+1];
		end

		// receive side, loopback taken from the internal transmit levels
		assign rxc_in = cfg_q[SSCI_LB_BIT] ? send_clock_line[c] : receive_clock_line[c];
		assign rxd_in = cfg_q[SSCI_LB_BIT] ? send_data_line[c] : receive_data_line[c];
		assign rxe_in = cfg_q[SSCI_LB_BIT] ? send_envelope_line[c] : receive_envelope_line[c];
		// upper select bit set: envelope ignored, every clock carries data
		assign rx_env = cfg_q[SSCI_RXE_LSB+1] ? 1'b1 : (rxe_in ^ cfg_q[SSCI_RXE_LSB]);
		assign rx_sample = (cfg_q[SSCI_RXC_EDG_BIT] ? (~rxc_prev_q & rxc_in)
			: (rxc_prev_q & ~rxc_in)) && rx_env;
		assign dbit = rxd_in ^ cfg_q[SSCI_RXD_POL_BIT];
		assign rx_close_bits = (rx_size_q != '0) && (rx_word_bits_q + 16'h0001 == rx_size_q);
		// a closed byte goes in when eight bits are in, the word closes, or the frame ends
		assign rx_push = (rx_sample && (rx_idx_q == 3'h7 || rx_close_bits))
			|| (rx_env_prev_q && !rx_env && rx_idx_q != 3'h0);
		assign rx_byte = rx_sample ? (ctrl_q[SSCI_CTL_LSBF_BIT] ? (rx_sh_q | (8'(dbit) << rx_idx_q))
			: {rx_sh_q[6:0], dbit}) : rx_sh_q;

		always_ff @(posedge sys_clk or negedge reset_n)
		begin
			if (!reset_n)
			begin
				rxc_prev_q     <= 1'b0;
				rx_env_prev_q  <= 1'b0;
				rx_cnt_q       <= '0;
				rx_word_bits_q <= '0;
				rx_idx_q       <= '0;
				rx_sh_q        <= '0;
				rx_wp_q        <= '0;
				rx_rp_q        <= '0;
			end
			else
			begin
				rxc_prev_q    <= rxc_in;
				rx_env_prev_q <= rx_env;
				if (ctrl_q[SSCI_CTL_RCLR_BIT] || (rx_env && !rx_env_prev_q))
					rx_cnt_q <= '0;
				else if (rx_sample)
					rx_cnt_q <= rx_cnt_q + 16'h0001;
				if (!rx_env)
					rx_word_bits_q <= '0;
				else if (rx_sample)
					rx_word_bits_q <= rx_close_bits ? 16'h0000 : rx_word_bits_q + 16'h0001;
				if (rx_push)
				begin
					rx_idx_q <= '0;
					rx_sh_q  <= '0;
					// overrun drops the byte
					if (rx_cnt != SSCI_FIFO_DEPTH)
					begin
						rx_mem[rx_wp_q[SSCI_FIFO_AW-1:0]] <= rx_byte;
						rx_wp_q <= rx_wp_q + 1'b1;
					end
				end
				else if (rx_sample)
				begin
					rx_sh_q  <= rx_byte;
					rx_idx_q <= rx_idx_q + 3'h1;
				end
				if (reg_rd && ssci_hit(reg_addr, SSCI_RX_DATA_BASE, c) && rx_cnt != '0)
					rx_rp_q <= rx_rp_q + 1'b1;
			end
		end
	end

	// read mux, data in the cycle after the strobe
	always_comb
	begin
		rdata_d = SSCI_UNMAPPED;
		if (reg_addr == SSCI_FW_KIND)
			rdata_d = {4{SSCI_FW_KIND_CODE}};
		if (reg_addr == SSCI_CAPS)
			rdata_d = SSCI_CAPS_CODE;
	end

	logic [31:0] ch_rd [SSCI_CHANNELS];
	for (c = 0; c < SSCI_CHANNELS; c++) begin : g_rd
		always_comb
		begin
			ch_rd[c] = '0;
			if (ssci_hit(reg_addr, SSCI_LINE_CFG_BASE, c))
				ch_rd[c] = g_ch[c].cfg_q;
			if (ssci_hit(reg_addr, SSCI_PIN_STAT_BASE, c))
				ch_rd[c] = {22'h0, spare_line_out[c], spare_line_in[c], auxiliary_clock_out[c],
					send_envelope_line[c], send_data_line[c], send_clock_line[c],
					auxiliary_clock_in[c], receive_envelope_line[c], receive_data_line[c],
					receive_clock_line[c]};
			if (ssci_hit(reg_addr, SSCI_TX_GAP_BASE, c))
				ch_rd[c] = g_ch[c].gap_q;
			if (ssci_hit(reg_addr, SSCI_RX_BITS_BASE, c))
				ch_rd[c] = {g_ch[c].rx_size_q, g_ch[c].rx_cnt_q};
			if (ssci_hit(reg_addr, SSCI_FIFO_LVL_BASE, c))
				ch_rd[c] = {11'h0, g_ch[c].rx_cnt, 11'h0, g_ch[c].tx_cnt};
			if (ssci_hit(reg_addr, SSCI_FIFO_CAP_BASE, c))
				ch_rd[c] = {SSCI_FIFO_SIZE, SSCI_FIFO_SIZE};
			if (ssci_hit(reg_addr, SSCI_CTRL_BASE, c))
				ch_rd[c] = g_ch[c].ctrl_q;
			if (ssci_hit(reg_addr, SSCI_RX_DATA_BASE, c))
				ch_rd[c] = {24'h0, g_ch[c].rx_mem[g_ch[c].rx_rp_q[SSCI_FIFO_AW-1:0]]};
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			reg_rdata <= '0;
		else if (reg_rd)
			reg_rdata <= rdata_d | ch_rd[0] | ch_rd[1] | ch_rd[2] | ch_rd[3];
	end
endmodule : ssci_top
`default_nettype wire

/* File: verif/ssci_asserts.sv */
// ssci_asserts: channel 0 pin behaviour seen at the block's ports
// assumes: bound into ssci_top; line configuration changes only through reg_wr
`timescale 1ns/1ps
`default_nettype none
module ssci_asserts
	import ssci_pkg::*;
(
	input wire logic                     sys_clk,
	input wire logic                     reset_n,
	input wire logic [SSCI_ADDR_W-1:0]   reg_addr,
	input wire logic [31:0]              reg_wdata,
	input wire logic                     reg_wr,
	input wire logic                     reg_rd,
	input wire logic [31:0]              reg_rdata,
	input wire logic [SSCI_CHANNELS-1:0] send_clock_line,
	input wire logic [SSCI_CHANNELS-1:0] send_data_line,
	input wire logic [SSCI_CHANNELS-1:0] send_envelope_line,
	input wire logic [SSCI_CHANNELS-1:0] auxiliary_clock_out,
	input wire logic [SSCI_CHANNELS-1:0] auxiliary_clock_oe,
	input wire logic [SSCI_CHANNELS-1:0] spare_line_out,
	input wire logic [SSCI_CHANNELS-1:0] spare_line_oe
);
	logic [31:0] cfg_q;
	logic [1:0]  env_hist_q;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			cfg_q <= SSCI_LINE_CFG_RST;
		else if (reg_wr && reg_addr == SSCI_LINE_CFG_BASE)
			cfg_q <= reg_wdata;
	end
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			env_hist_q <= 2'h3;
		else
			env_hist_q <= {env_hist_q[0], send_envelope_line[0]};
	end
	// idle only after three negated samples, so a one-cycle skew is not flagged
	wire logic idle_w = cfg_q[5:4] == 2'h0 && !send_envelope_line[0] && env_hist_q == 2'h0;
	sequence aux_high_s;
		cfg_q[10:9] == 2'h1 && auxiliary_clock_out[0];
	endsequence
	sequence aux_low_s;
		##[1:600] (!auxiliary_clock_out[0] || cfg_q[10:9] != 2'h1);
	endsequence
	spare_off_a: assert property (!cfg_q[12] && $stable(cfg_q) |-> !spare_line_oe[0])
		else $error("spare pin driven while disabled");
	spare_drive_a: assert property (cfg_q[12] && $stable(cfg_q) |-> spare_line_oe[0] && spare_line_out[0] == cfg_q[11])
		else $error("spare pin constant wrong");
	aux_tristate_a: assert property (cfg_q[10:9] == 2'h0 && $stable(cfg_q) |-> !auxiliary_clock_oe[0])
		else $error("auxiliary clock not released");
	aux_const_a: assert property (cfg_q[10] && $stable(cfg_q) |-> auxiliary_clock_oe[0] && auxiliary_clock_out[0] == cfg_q[9])
		else $error("auxiliary clock constant wrong");
	aux_toggles_a: assert property (aux_high_s |-> aux_low_s)
		else $error("auxiliary clock stuck high");
	env_const_a: assert property (cfg_q[5] && $stable(cfg_q) |-> send_envelope_line[0] == cfg_q[4])
		else $error("envelope constant wrong");
	data_idle_a: assert property (idle_w && !cfg_q[8] && !cfg_q[6] |-> send_data_line[0] == cfg_q[19])
		else $error("data line not at idle level");
	clock_idle_a: assert property (idle_w && cfg_q[3] && !cfg_q[2] |-> send_clock_line[0] == cfg_q[20])
		else $error("send clock not held at idle level");
	unmapped_read_a: assert property (reg_rd && reg_addr < 12'h080 |=> reg_rdata == SSCI_UNMAPPED)
		else $error("unmapped read not zero");
endmodule : ssci_asserts
`default_nettype wire

/* File: verif/ssci_far_end.sv */
// ssci_far_end: far serial device on channel 0, sends framed bytes, records sent bits
// assumes: envelopes active high, the block samples received data on the falling clock
`timescale 1ns/1ps
`default_nettype none
module ssci_far_end
(
	input  wire logic send_clock_line,
	input  wire logic send_data_line,
	input  wire logic send_envelope_line,
	output logic      receive_clock_line,
	output logic      receive_data_line,
	output logic      receive_envelope_line
);
	logic [15:0] cap_q = 16'h0000;
	int          nbits = 0;
	int          nwords = 0;
	initial
	begin
		receive_clock_line = 1'b0;
		receive_data_line = 1'b1;
		receive_envelope_line = 1'b0;
	end
	// sent data moves on the rising edge, so the falling edge is the safe sample point
	always @(negedge send_clock_line)
	begin
		if (send_envelope_line === 1'b1)
		begin
			cap_q = {cap_q[14:0], send_data_line};
			nbits++;
		end
	end
	always @(posedge send_envelope_line)
		nwords++;
	task automatic clear();
		nbits = 0;
		nwords = 0;
	endtask : clear
	task automatic send_word(input logic [7:0] v);
		receive_envelope_line = 1'b1;
		#40;
		for (int i = 7; i >= 0; i--)
		begin
			receive_clock_line = 1'b1;
			receive_data_line = v[i];
			#40 receive_clock_line = 1'b0;
			#40;
		end
		receive_envelope_line = 1'b0;
		// released data shows the inverse so a stale bit cannot pass for a real one
		receive_data_line = ~receive_data_line;
	endtask : send_word
endmodule : ssci_far_end
`default_nettype wire

/* File: verif/tb_top.sv */
// tb_top: self-checking bench for ssci_top; channel 0 talks to ssci_far_end
// assumes: 100 MHz sys_clk, read data taken in the cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
	$display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); end end
module tb_top
	import ssci_pkg::*;
;
	logic        sys_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [11:0] reg_addr = 12'h000;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [31:0] rv;
	logic [4:0]  pin_v = 5'h00;
	logic [3:0]  s_clk, s_dat, s_env, a_out, a_oe, sp_out, sp_oe;
	logic        f_clk, f_dat, f_env;
	int          num_errors = 0;
	int          n_compared = 0;
	always #5 sys_clk = ~sys_clk;
	ssci_top ssci_top_i (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.ext_clock_in(4'h0), .receive_clock_line({{3{pin_v[0]}}, f_clk}),
		.receive_data_line({{3{pin_v[1]}}, f_dat}), .receive_envelope_line({{3{pin_v[2]}}, f_env}),
		.auxiliary_clock_in({4{pin_v[3]}}), .spare_line_in({4{pin_v[4]}}),
		.send_clock_line(s_clk), .send_data_line(s_dat), .send_envelope_line(s_env),
		.auxiliary_clock_out(a_out), .auxiliary_clock_oe(a_oe), .spare_line_out(sp_out),
		.spare_line_oe(sp_oe));
	ssci_far_end ssci_far_end_i (.send_clock_line(s_clk[0]), .send_data_line(s_dat[0]),
		.send_envelope_line(s_env[0]), .receive_clock_line(f_clk),
		.receive_data_line(f_dat), .receive_envelope_line(f_env));
	task automatic complete_run();
		if (num_errors == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : complete_run
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [11:0] a);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		rv = reg_rdata;
	endtask : rd
	task automatic wait_bits(input int n);
		for (int i = 0; i < 3000 && ssci_far_end_i.nbits < n; i++)
			@(posedge sys_clk);
		if (ssci_far_end_i.nbits < n)
		begin
			`CHK(ssci_far_end_i.nbits, n)
			complete_run();
		end
		else
			#1;
	endtask : wait_bits
	task automatic poll_rx();
		rv = 32'h0000_0000;
		for (int i = 0; i < 400 && rv[31:16] == 16'h0000; i++)
			rd(SSCI_FIFO_LVL_BASE);
		`CHK(rv[31:16], 16'h0001)
	endtask : poll_rx
	task automatic t_reset_values();
		rd(SSCI_LINE_CFG_BASE);
		`CHK(rv, SSCI_LINE_CFG_RST)
		rd(SSCI_TX_GAP_BASE);
		`CHK(rv, SSCI_TX_GAP_RST)
		rd(SSCI_FIFO_CAP_BASE + 12'h004);
		`CHK(rv, {SSCI_FIFO_SIZE, SSCI_FIFO_SIZE})
		rd(12'h000);
		`CHK(rv, SSCI_UNMAPPED)
	endtask : t_reset_values
	task automatic t_pins();
		for (int v = 0; v < 4; v++)
		begin
			// same code in the envelope, auxiliary clock and spare fields
			wr(SSCI_LINE_CFG_BASE, 32'(v) * 32'h0000_0A10);
			@(posedge sys_clk);
			#1;
			`CHK(s_env[0], v[0])
			`CHK(sp_oe[0], v[1])
			`CHK(a_oe[0], v != 0)
			if (v > 1)
				`CHK({sp_out[0], a_out[0]}, {v[0], v[0]})
			repeat (25) @(posedge sys_clk);
		end
		wr(SSCI_LINE_CFG_BASE + 12'h004, 32'h0000_1600);
		pin_v <= 5'h1D;
		repeat (4) @(posedge sys_clk);
		rd(SSCI_PIN_STAT_BASE + 12'h004);
		`CHK(rv & 32'h0000_038F, 32'h0000_018D)
		pin_v <= 5'h02;
		repeat (4) @(posedge sys_clk);
		rd(SSCI_PIN_STAT_BASE + 12'h004);
		`CHK(rv & 32'h0000_038F, 32'h0000_0082)
	endtask : t_pins
	task automatic t_fifo();
		// one write past capacity must be dropped
		for (int i = 0; i < 17; i++)
			wr(SSCI_TX_DATA_BASE + 12'h00C, 32'(i));
		rd(SSCI_FIFO_LVL_BASE + 12'h00C);
		`CHK(rv[15:0], 16'h0010)
		rd(SSCI_FIFO_LVL_BASE);
		`CHK(rv, 32'h0000_0000)
	endtask : t_fifo
	task automatic t_tx();
		wr(SSCI_LINE_CFG_BASE, 32'h0008_0008);
		`CHK({s_clk[0], s_dat[0]}, 2'b01)
		wr(SSCI_TX_GAP_BASE, 32'h0003_0008);
		wr(SSCI_TX_DATA_BASE, 32'h0000_00A5);
		wr(SSCI_TX_DATA_BASE, 32'h0000_003C);
		ssci_far_end_i.clear();
		wr(SSCI_CTRL_BASE, 32'h0000_0401);
		wait_bits(16);
		`CHK(ssci_far_end_i.cap_q, 16'hA53C)
		`CHK(ssci_far_end_i.nwords, 2)
		wr(SSCI_LINE_CFG_BASE, 32'h0008_0048);
		ssci_far_end_i.clear();
		wr(SSCI_CTRL_BASE, 32'h0000_0403);
		wr(SSCI_TX_DATA_BASE, 32'h0000_0001);
		wait_bits(8);
		`CHK(ssci_far_end_i.cap_q[7:0], 8'h7F)
		wr(SSCI_CTRL_BASE, 32'h0000_0400);
	endtask : t_tx
	task automatic t_rx();
		wr(SSCI_LINE_CFG_BASE, 32'h0000_0000);
		ssci_far_end_i.send_word(8'hC5);
		poll_rx();
		rd(SSCI_RX_DATA_BASE);
		`CHK(rv[7:0], 8'hC5)
		wr(SSCI_LINE_CFG_BASE, 32'h0001_0000);
		ssci_far_end_i.send_word(8'hC5);
		poll_rx();
		rd(SSCI_RX_DATA_BASE);
		`CHK(rv[7:0], 8'h3A)
		rd(SSCI_RX_BITS_BASE);
		`CHK(rv[15:0], 16'h0008)
		wr(SSCI_CTRL_BASE, 32'h0000_0404);
		// the clear bit acts one cycle after it lands
		@(posedge sys_clk);
		rd(SSCI_RX_BITS_BASE);
		`CHK(rv[15:0], 16'h0000)
	endtask : t_rx
	task automatic t_loop();
		wr(SSCI_LINE_CFG_BASE, 32'h0088_0008);
		wr(SSCI_CTRL_BASE, 32'h0000_0401);
		wr(SSCI_TX_DATA_BASE, 32'h0000_0096);
		poll_rx();
		rd(SSCI_RX_DATA_BASE);
		`CHK(rv[7:0], 8'h96)
	endtask : t_loop
	initial
	begin
		repeat (12) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		#1;
		t_reset_values();
		t_pins();
		t_fifo();
		t_tx();
		t_rx();
		t_loop();
		complete_run();
	end
endmodule : tb_top
bind ssci_top ssci_asserts ssci_asserts_i (.sys_clk(sys_clk), .reset_n(reset_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .send_clock_line(send_clock_line), .send_data_line(send_data_line),
	.send_envelope_line(send_envelope_line), .auxiliary_clock_out(auxiliary_clock_out),
	.auxiliary_clock_oe(auxiliary_clock_oe), .spare_line_out(spare_line_out),
	.spare_line_oe(spare_line_oe));
`default_nettype wire
